// [logic/scp_pkg.sv]
// constants and types shared by the serial configuration port
package scp_pkg;

    // register map, byte addresses
    localparam logic [12:0] SCP_CFG_ADDR   = 13'h0000;
    localparam logic [12:0] SCP_RBSEL_ADDR = 13'h0004;
    localparam logic [12:0] SCP_UPD_ADDR   = 13'h0232;
    localparam logic [12:0] SCP_TOP_ADDR   = 13'h0232;
    localparam logic [12:0] SCP_BOT_ADDR   = 13'h0000;

    // serial_port_config fields and reset value
    localparam int          SCP_CFG_DIR_BIT = 0;
    localparam int          SCP_CFG_LSB_BIT = 1;
    localparam logic [7:0]  SCP_CFG_RESET   = 8'h18;

    // readback_source_select and register_update_strobe fields
    localparam int          SCP_RBSEL_BIT  = 0;
    localparam logic        SCP_RBSEL_RESET = 1'b0;
    localparam int          SCP_UPD_BIT    = 0;

    // instruction word layout
    localparam logic [3:0]  SCP_INSTR_LAST = 4'hF;
    localparam int          SCP_INS_RW_BIT = 15;
    localparam int          SCP_LEN_MSB    = 14;
    localparam int          SCP_LEN_LSB    = 13;
    localparam int          SCP_ADDR_MSB   = 12;
    localparam logic [1:0]  SCP_LEN_STREAM = 2'h3;

    // register storage
    localparam int          SCP_MEM_DEPTH  = 563;
    localparam int          SCP_MEM_AW     = 10;

    typedef enum logic [4:0] {
        SCP_ST_IDLE  = 5'b00001,
        SCP_ST_INSTR = 5'b00010,
        SCP_ST_DATA  = 5'b00100,
        SCP_ST_STALL = 5'b01000,
        SCP_ST_DONE  = 5'b10000
    } scp_state_e;

endpackage

// [logic/scp_mem_if.sv]
// link between the port logic and the register storage
`timescale 1ns/1ps
`default_nettype none

interface scp_mem_if
    import scp_pkg::*;
();
    logic                  wr_en;
    logic [SCP_MEM_AW-1:0] wr_addr;
    logic [7:0]            wr_data;
    logic                  commit;
    logic [SCP_MEM_AW-1:0] rd_addr;
    logic                  rd_sel;
    logic [7:0]            rd_data;

    modport port (
        output wr_en,
        output wr_addr,
        output wr_data,
        output commit,
        output rd_addr,
        output rd_sel,
        input  rd_data
    );

    modport mem (
        input  wr_en,
        input  wr_addr,
        input  wr_data,
        input  commit,
        input  rd_addr,
        input  rd_sel,
        output rd_data
    );
endinterface

`default_nettype wire

// [logic/scp_regmem.sv]
// shadow buffer and active registers with registered readback
`timescale 1ns/1ps
`default_nettype none

module scp_regmem
    import scp_pkg::*;
(
    input  wire logic  sys_clk_i,
    input  wire logic  rst_i,
    scp_mem_if.mem     bus
);

    logic [7:0] shadow [SCP_MEM_DEPTH];
    logic [7:0] active [SCP_MEM_DEPTH];

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < SCP_MEM_DEPTH; i++)
            begin
                shadow[i] <= 8'h00;
            end
        end
        else if (bus.wr_en)
        begin
            shadow[bus.wr_addr] <= bus.wr_data;
        end
    end

    // all buffered bytes become active together
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < SCP_MEM_DEPTH; i++)
            begin
                active[i] <= 8'h00;
            end
        end
        else if (bus.commit)
        begin
            for (int i = 0; i < SCP_MEM_DEPTH; i++)
            begin
                active[i] <= shadow[i];
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            bus.rd_data <= 8'h00;
        end
        else if (bus.rd_sel)
        begin
            bus.rd_data <= active[bus.rd_addr];
        end
        else
        begin
            bus.rd_data <= shadow[bus.rd_addr];
        end
    end

endmodule

`default_nettype wire

// [logic/scp_serial_port.sv]
// serial configuration port target with shadow and active registers
`timescale 1ns/1ps
`default_nettype none


module scp_serial_port
    import scp_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic sclk_i,
    input  wire logic cs_n_i,
    input  wire logic sdio_i,
    output logic      sdio_o,
    output logic      sdio_oe_o,
    output logic      serial_readback_out_o,
    output logic      serial_readback_out_oe_o
);

    scp_mem_if mem_bus ();

    scp_regmem u_regmem (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .bus       (mem_bus.mem)
    );

    // next address after a byte, wrapping at the ends of the map
    function automatic logic [12:0] next_addr(input logic [12:0] a,
                                              input logic        lsb);
        logic [12:0] r;
        r = a;
        if (lsb)
        begin
            r = (a == SCP_TOP_ADDR) ? SCP_BOT_ADDR : 13'(a + 13'h0001);
        end
        else
        begin
            r = (a == SCP_BOT_ADDR) ? SCP_TOP_ADDR : 13'(a - 13'h0001);
        end
        return r;
    endfunction

    function automatic logic first_bit(input logic [7:0] b,
                                       input logic       lsb);
        return lsb ? b[0] : b[7];
    endfunction

    function automatic logic [7:0] shift_out(input logic [7:0] b,
                                             input logic       lsb);
        return lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
    endfunction

    // two-stage synchronisers for the pins
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic       sclk_d;
    logic       cs_d;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            sync_a <= 3'h6;
            sync_b <= 3'h6;
            sclk_d <= 1'b0;
            cs_d   <= 1'b1;
        end
        else
        begin
            sync_a <= {cs_n_i, sclk_i, sdio_i};
            sync_b <= sync_a;
            sclk_d <= sync_b[1];
            cs_d   <= sync_b[2];
        end
    end

    logic cs_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;
    logic din;

    assign din       = sync_b[0];
    assign cs_s      = sync_b[2];
    assign sclk_rise = sync_b[1] & ~sclk_d & ~cs_s;
    assign sclk_fall = ~sync_b[1] & sclk_d & ~cs_s;
    assign cs_rise   = cs_s & ~cs_d;
    assign cs_fall   = ~cs_s & cs_d;

    // control registers
    logic [7:0] port_cfg;
    logic       rb_sel;
    logic       lsb_first;
    logic       dir_sel;

    assign lsb_first = port_cfg[SCP_CFG_LSB_BIT];
    assign dir_sel   = port_cfg[SCP_CFG_DIR_BIT];

    // transfer state
    scp_state_e  state;
    logic [3:0]  bit_cnt;
    logic [15:0] ins_sh;
    logic [7:0]  rx_sh;
    logic [12:0] addr;
    logic        is_read;
    logic        is_stream;
    logic [1:0]  bytes_left;
    logic        resume_data;

    logic [15:0] next_ins;
    logic [7:0]  next_rx;
    logic        byte_done;
    logic        last_byte;

    assign next_ins  = lsb_first ? {din, ins_sh[15:1]}
                                 : {ins_sh[14:0], din};
    assign next_rx   = lsb_first ? {din, rx_sh[7:1]} : {rx_sh[6:0], din};
    assign byte_done = (state == SCP_ST_DATA) && sclk_rise
                       && (bit_cnt[2:0] == 3'h7);
    assign last_byte = is_stream ? (addr == SCP_TOP_ADDR)
                                 : (bytes_left == 2'h0);

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state       <= SCP_ST_IDLE;
            bit_cnt     <= 4'h0;
            ins_sh      <= 16'h0000;
            rx_sh       <= 8'h00;
            addr        <= 13'h0000;
            is_read     <= 1'b0;
            is_stream   <= 1'b0;
            bytes_left  <= 2'h0;
            resume_data <= 1'b0;
        end
        else if (cs_rise)
        begin
            case (state)
                SCP_ST_INSTR:
                begin
                    // byte boundary inside the instruction
                    if ((bit_cnt[2:0] == 3'h0) && (bit_cnt != 4'h0))
                    begin
                        state       <= SCP_ST_STALL;
                        resume_data <= 1'b0;
                    end
                    else
                    begin
                        state   <= SCP_ST_IDLE;
                        bit_cnt <= 4'h0;
                    end
                end
                SCP_ST_DATA:
                begin
                    if (!is_stream && (bit_cnt[2:0] == 3'h0))
                    begin
                        state       <= SCP_ST_STALL;
                        resume_data <= 1'b1;
                    end
                    else
                    begin
                        state   <= SCP_ST_IDLE;
                        bit_cnt <= 4'h0;
                    end
                end
                SCP_ST_STALL:
                begin
                    state <= SCP_ST_STALL;
                end
                default:
                begin
                    state   <= SCP_ST_IDLE;
                    bit_cnt <= 4'h0;
                end
            endcase
        end
        else
        begin
            case (state)
                SCP_ST_IDLE:
                begin
                    if (sclk_rise)
                    begin
                        ins_sh  <= next_ins;
                        bit_cnt <= 4'h1;
                        state   <= SCP_ST_INSTR;
                    end
                end
                SCP_ST_INSTR:
                begin
                    if (sclk_rise)
                    begin
                        ins_sh  <= next_ins;
                        bit_cnt <= 4'(bit_cnt + 4'h1);
                        if (bit_cnt == SCP_INSTR_LAST)
                        begin
                            is_read   <= next_ins[SCP_INS_RW_BIT];
                            is_stream <= next_ins[SCP_LEN_MSB:SCP_LEN_LSB]
                                         == SCP_LEN_STREAM;
                            bytes_left <= next_ins[SCP_LEN_MSB:SCP_LEN_LSB];
                            addr      <= next_ins[SCP_ADDR_MSB:0];
                            bit_cnt   <= 4'h0;
                            state     <= SCP_ST_DATA;
                        end
                    end
                end
                SCP_ST_DATA:
                begin
                    if (sclk_rise)
                    begin
                        rx_sh   <= next_rx;
                        bit_cnt <= {1'b0, 3'(bit_cnt[2:0] + 3'h1)};
                    end
                    if (byte_done)
                    begin
                        if (last_byte)
                        begin
                            state <= SCP_ST_DONE;
                        end
                        else
                        begin
                            addr       <= next_addr(addr, lsb_first);
                            bytes_left <= 2'(bytes_left - 2'h1);
                        end
                    end
                end
                SCP_ST_STALL:
                begin
                    if (cs_fall)
                    begin
                        state <= resume_data ? SCP_ST_DATA : SCP_ST_INSTR;
                    end
                end
                SCP_ST_DONE:
                begin
                    state <= SCP_ST_DONE;
                end
                default:
                begin
                    state   <= SCP_ST_IDLE;
                    bit_cnt <= 4'h0;
                end
            endcase
        end
    end

    // completed write bytes: buffer, port config and update strobe
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            mem_bus.wr_en   <= 1'b0;
            mem_bus.wr_addr <= '0;
            mem_bus.wr_data <= 8'h00;
            mem_bus.commit  <= 1'b0;
            port_cfg        <= SCP_CFG_RESET;
            rb_sel          <= SCP_RBSEL_RESET;
        end
        else
        begin
            mem_bus.wr_en  <= 1'b0;
            mem_bus.commit <= 1'b0;
            if (byte_done && !is_read && (addr <= SCP_TOP_ADDR))
            begin
                mem_bus.wr_en   <= 1'b1;
                mem_bus.wr_addr <= addr[SCP_MEM_AW-1:0];
                mem_bus.wr_data <= next_rx;
                if (addr == SCP_CFG_ADDR)
                begin
                    port_cfg <= next_rx;
                end
                if (addr == SCP_RBSEL_ADDR)
                begin
                    rb_sel <= next_rx[SCP_RBSEL_BIT];
                end
                if (addr == SCP_UPD_ADDR)
                begin
                    mem_bus.commit <= next_rx[SCP_UPD_BIT];
                end
            end
        end
    end

    assign mem_bus.rd_addr = addr[SCP_MEM_AW-1:0];
    assign mem_bus.rd_sel  = rb_sel;

    // readback byte, update bit always reads back cleared
    logic [7:0] rd_byte;

    always_comb
    begin
        rd_byte = mem_bus.rd_data;
        if (addr == SCP_CFG_ADDR)
        begin
            rd_byte = port_cfg;
        end
        else if ((addr == SCP_UPD_ADDR) || (addr > SCP_TOP_ADDR))
        begin
            rd_byte = 8'h00;
        end
    end

    // read data path
    logic [7:0] tx_sh;
    logic       out_bit;
    logic       drive_rd;

    assign drive_rd = (state == SCP_ST_DATA) && is_read && !cs_s;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            tx_sh   <= 8'h00;
            out_bit <= 1'b0;
        end
        else if (drive_rd && (bit_cnt[2:0] == 3'h0))
        begin
            out_bit <= first_bit(rd_byte, lsb_first);
            tx_sh   <= shift_out(rd_byte, lsb_first);
        end
        else if (drive_rd && sclk_fall)
        begin
            out_bit <= first_bit(tx_sh, lsb_first);
            tx_sh   <= shift_out(tx_sh, lsb_first);
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            sdio_o                   <= 1'b0;
            sdio_oe_o                <= 1'b0;
            serial_readback_out_o    <= 1'b0;
            serial_readback_out_oe_o <= 1'b0;
        end
        else
        begin
            sdio_o                   <= out_bit;
            serial_readback_out_o    <= out_bit;
            sdio_oe_o                <= drive_rd && !dir_sel;
            serial_readback_out_oe_o <= drive_rd && dir_sel;
        end
    end

endmodule

`default_nettype wire

// [sim/scp_serial_port_asserts.sv]
// pin-level assertions for the serial configuration port
`timescale 1ns/1ps
`default_nettype none

module scp_serial_port_asserts
    import scp_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdio_i,
    input wire logic sdio_o,
    input wire logic sdio_oe_o,
    input wire logic serial_readback_out_o,
    input wire logic serial_readback_out_oe_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    logic       sclk_q;
    logic [7:0] rises;
    logic       any_oe;

    assign any_oe = sdio_oe_o | serial_readback_out_oe_o;

    // sclk rises seen in the current selection
    always_ff @(posedge sys_clk_i)
    begin
        sclk_q <= sclk_i;
        if (rst_i || cs_n_i)
            rises <= 8'h00;
        else if (sclk_i && !sclk_q && rises != 8'hFF)
            rises <= rises + 8'h01;
    end

    sequence cs_idle;
        cs_n_i [*6];
    endsequence

    sequence all_quiet;
        !any_oe && !sdio_o && !serial_readback_out_o;
    endsequence

    a_one_pin: assert property (!(sdio_oe_o && serial_readback_out_oe_o))
        else $error("both data pins driven");
    a_cs_release: assert property (cs_idle |-> !any_oe)
        else $error("data pin driven while deselected");
    a_reset_quiet: assert property ($fell(rst_i) |-> all_quiet)
        else $error("outputs active at reset release");
    a_start_quiet: assert property ($fell(rst_i) |-> ##1 all_quiet [*2])
        else $error("outputs active soon after reset");
    a_drive_sel: assert property ($rose(any_oe) |-> !$past(cs_n_i, 2))
        else $error("drive began without selection");
    a_after_instr: assert property ($rose(any_oe) |-> rises >= 8'h10)
        else $error("drive began before 16 clock rises");
    a_same_bit: assert property (
        serial_readback_out_oe_o |-> serial_readback_out_o == sdio_o)
        else $error("readback pins disagree");
    a_bit_held: assert property (
        $fell(sclk_i) && sdio_oe_o && $past(sdio_oe_o, 6) |-> $stable(sdio_o))
        else $error("read bit moved at falling edge");
endmodule

bind scp_serial_port scp_serial_port_asserts u_scp_serial_port_asserts (
    .sys_clk_i                (sys_clk_i),
    .rst_i                    (rst_i),
    .sclk_i                   (sclk_i),
    .cs_n_i                   (cs_n_i),
    .sdio_i                   (sdio_i),
    .sdio_o                   (sdio_o),
    .sdio_oe_o                (sdio_oe_o),
    .serial_readback_out_o    (serial_readback_out_o),
    .serial_readback_out_oe_o (serial_readback_out_oe_o)
);

`default_nettype wire

// [sim/scp_host_model.sv]
// host-side serial master model for the configuration link
`timescale 1ns/1ps
`default_nettype none

module scp_host_model (
    input  wire logic       sys_clk_i,
    input  wire logic       lsb_i,
    input  wire logic       dir_i,
    input  wire logic       sdio_i,
    input  wire logic       sdo_i,
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic            sdio_o,
    output logic            sdio_oe_o,
    output logic            got_o,
    output logic [7:0]      got_byte_o
);
    initial
    begin
        sclk_o = 1'h0;
        cs_n_o = 1'h1;
        sdio_o = 1'h0;
        sdio_oe_o = 1'h0;
        got_o = 1'h0;
        got_byte_o = 8'h00;
    end

    // select edge then a settling gap; deselect releases the data pin
    task automatic sel(input logic v);
    begin
        @(posedge sys_clk_i);
        cs_n_o <= v;
        if (v)
            sdio_oe_o <= 1'h0;
        repeat (5) @(posedge sys_clk_i);
    end
    endtask

    // n bits, 320 ns each; read bits taken just before sclk falls
    task automatic bits(input logic [7:0] d, input logic drv,
                        input int n, output logic [7:0] r);
    begin
        r = 8'h00;
        @(posedge sys_clk_i);
        for (int i = 0; i < n; i++)
        begin
            sdio_o <= lsb_i ? d[i] : d[7 - i];
            sdio_oe_o <= drv;
            repeat (4) @(posedge sys_clk_i);
            sclk_o <= 1'h1;
            repeat (4) @(posedge sys_clk_i);
            r[lsb_i ? i : 7 - i] = dir_i ? sdo_i : sdio_i;
            sclk_o <= 1'h0;
        end
        if (!drv)
        begin
            got_byte_o <= r;
            got_o <= 1'h1;
            @(posedge sys_clk_i);
            got_o <= 1'h0;
        end
    end
    endtask

    task automatic instr(input logic [15:0] w, input logic stall);
        logic [7:0] r;
    begin
        bits(lsb_i ? w[7:0] : w[15:8], 1'h1, 8, r);
        if (stall)
        begin
            sel(1'h1);
            sel(1'h0);
        end
        bits(lsb_i ? w[15:8] : w[7:0], 1'h1, 8, r);
    end
    endtask
endmodule

`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none

module testbench
    import scp_pkg::*;
;
    logic       sys_clk, rst, sclk, cs_n, h_d, h_oe, pat;
    logic       d_o, d_oe, r_o, r_oe, sdio_line, sdo_line;
    logic       lsb, dir, got;
    logic [7:0] got_byte, r, e;
    logic [7:0] v [3];
    logic [7:0] exp_q [$];
    int         mismatches, cmp_count, seed;

    // released lines show a pattern that changes every cycle
    assign sdio_line = d_oe ? d_o : h_oe ? h_d : pat;
    assign sdo_line = r_oe ? r_o : ~pat;

    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) pat <= ~pat;

    scp_serial_port u_scp_serial_port (
        .sys_clk_i                (sys_clk),
        .rst_i                    (rst),
        .sclk_i                   (sclk),
        .cs_n_i                   (cs_n),
        .sdio_i                   (sdio_line),
        .sdio_o                   (d_o),
        .sdio_oe_o                (d_oe),
        .serial_readback_out_o    (r_o),
        .serial_readback_out_oe_o (r_oe)
    );

    scp_host_model u_scp_host_model (
        .sys_clk_i  (sys_clk),
        .lsb_i      (lsb),
        .dir_i      (dir),
        .sdio_i     (sdio_line),
        .sdo_i      (sdo_line),
        .sclk_o     (sclk),
        .cs_n_o     (cs_n),
        .sdio_o     (h_d),
        .sdio_oe_o  (h_oe),
        .got_o      (got),
        .got_byte_o (got_byte)
    );

    always @(posedge sys_clk)
        if (got)
        begin
            e = exp_q.pop_front();
            cmp_count++;
            if (got_byte !== e)
            begin
                mismatches++;
                $display("mismatch t=%0t got=%h exp=%h", $time, got_byte, e);
            end
        end

    // one framed transfer; read bytes go to the queue as expectations
    task automatic xfer(input logic rw, input logic [1:0] len,
                        input logic [12:0] a, input int n,
                        input logic [31:0] d, input logic stall);
        logic [7:0] b;
    begin
        u_scp_host_model.sel(1'h0);
        u_scp_host_model.instr({rw, len, a}, stall);
        for (int k = 0; k < n; k++)
        begin
            b = d[8 * (n - 1 - k) +: 8];
            if (rw)
                exp_q.push_back(b);
            if (stall)
            begin
                u_scp_host_model.sel(1'h1);
                u_scp_host_model.sel(1'h0);
            end
            u_scp_host_model.bits(b, !rw, 8, r);
        end
        u_scp_host_model.sel(1'h1);
    end
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic close_out;
    begin
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    // whole run is near 6000 cycles; allow several times that
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        close_out();
    end

    initial
    begin
        sys_clk = 1'h0;
        rst = 1'h1;
        pat = 1'h0;
        lsb = 1'h0;
        dir = 1'h0;
        mismatches = 0;
        cmp_count = 0;
        seed = 32'h718A;
        for (int i = 0; i < 3; i++)
            v[i] = 8'($random(seed));
        repeat (12) @(posedge sys_clk);
        rst <= 1'h0;
        repeat (4) @(posedge sys_clk);
        xfer(1, 2'h0, SCP_CFG_ADDR, 1, {24'h0, SCP_CFG_RESET}, 0);
        xfer(1, 2'h0, SCP_RBSEL_ADDR, 1, 32'h0, 0);
        done("defaults");
        xfer(0, 2'h2, 13'h0012, 3, {8'h0, v[0], v[1], v[2]}, 1);
        xfer(1, 2'h1, 13'h0012, 2, {16'h0, v[0], v[1]}, 0);
        xfer(1, 2'h0, 13'h0010, 1, {24'h0, v[2]}, 0);
        xfer(0, 2'h0, SCP_RBSEL_ADDR, 1, 32'h1, 0);
        xfer(1, 2'h0, 13'h0012, 1, 32'h0, 0);
        xfer(0, 2'h0, SCP_UPD_ADDR, 1, 32'h1, 0);
        xfer(1, 2'h2, 13'h0012, 3, {8'h0, v[0], v[1], v[2]}, 0);
        xfer(1, 2'h0, SCP_UPD_ADDR, 1, 32'h0, 0);
        done("buffer and update");
        // stall after first instruction byte, then a 3-clock abort
        u_scp_host_model.sel(1'h0);
        u_scp_host_model.bits(8'h00, 1'h1, 8, r);
        u_scp_host_model.sel(1'h1);
        u_scp_host_model.sel(1'h0);
        u_scp_host_model.bits(8'h00, 1'h1, 3, r);
        u_scp_host_model.sel(1'h1);
        // write to readback select cut off after 5 data bits
        u_scp_host_model.sel(1'h0);
        u_scp_host_model.instr({3'h0, SCP_RBSEL_ADDR}, 1'h0);
        u_scp_host_model.bits(8'h00, 1'h1, 5, r);
        u_scp_host_model.sel(1'h1);
        xfer(1, 2'h0, SCP_RBSEL_ADDR, 1, 32'h1, 0);
        done("abort");
        xfer(1, 2'h3, 13'h0002, 4, {16'h0, SCP_CFG_RESET, 8'h0}, 0);
        done("stream");
        xfer(0, 2'h0, SCP_CFG_ADDR, 1, 32'h99, 0);
        dir <= 1'h1;
        xfer(1, 2'h0, SCP_CFG_ADDR, 1, 32'h99, 0);
        xfer(0, 2'h0, SCP_CFG_ADDR, 1, {24'h0, SCP_CFG_RESET}, 0);
        dir <= 1'h0;
        done("direction");
        xfer(0, 2'h0, SCP_CFG_ADDR, 1, 32'h5A, 0);
        lsb <= 1'h1;
        xfer(0, 2'h1, 13'h0020, 2, {16'h0, v[0], v[1]}, 0);
        xfer(0, 2'h0, SCP_RBSEL_ADDR, 1, 32'h0, 0);
        xfer(1, 2'h1, 13'h0020, 2, {16'h0, v[0], v[1]}, 0);
        xfer(0, 2'h0, SCP_CFG_ADDR, 1, {24'h0, SCP_CFG_RESET}, 0);
        lsb <= 1'h0;
        xfer(1, 2'h0, SCP_CFG_ADDR, 1, {24'h0, SCP_CFG_RESET}, 0);
        done("lsb first");
        // stream write across config and update: host supplies their values
        xfer(0, 2'h3, 13'h0001, 3, {8'h0, v[2], SCP_CFG_RESET, 8'h00}, 0);
        xfer(1, 2'h0, 13'h0001, 1, {24'h0, v[2]}, 0);
        xfer(1, 2'h0, SCP_CFG_ADDR, 1, {24'h0, SCP_CFG_RESET}, 0);
        done("stream write");
        repeat (4) @(posedge sys_clk);
        if (exp_q.size() != 0)
            mismatches++;
        close_out();
    end
endmodule

`default_nettype wire
